// file: core/tcl_regs.vh
// Constants for the tool changer lock sequencer: register map and timing.
// Assumes a 50 MHz clock and an AXI4-Lite register bus with 32-bit data.
//
// Notes on behaviour
// - Commands in, status out, all active high.
// - After power-up hold still until commanded.
// - Accepted command drives mechanism to completion.
// - Commands shorter than 50 ms are ignored.
// - Every transition finishes within one second.
// - Proximity input is not used here.
// - Repeated command in same position ignored.
// - Unhomed release uses current method, sets zero.
// - Homed release positions, retries once, aborts.
// - Unhomed lock uses current method.
// - Homed lock positions, retries twice, aborts.
// - Home established on first release.
// - Locked at power-up retightens, reports engaged.
// - Extended without tool and no holding force reports neither status.
// - Holding force applied while locked.
`ifndef TCL_REGS_VH
`define TCL_REGS_VH

`define TCL_ADDR_CTRL        4'h0
`define TCL_ADDR_STATUS      4'h4
`define TCL_ADDR_POS         4'h8
`define TCL_ADDR_TOL         4'hC

`define TCL_CTRL_HOLD_BIT    0
`define TCL_CTRL_RESET       32'h0000_0001
`define TCL_TOL_RESET        16'h0010
`define TCL_UNLOCK_POS       16'h0000
`define TCL_LOCK_POS         16'h0800

`define TCL_CLK_HZ           50000000
`define TCL_MIN_CMD_MS       50
`define TCL_MAX_MOVE_MS      1000
`define TCL_MIN_CMD_CYC      ((`TCL_CLK_HZ / 1000) * `TCL_MIN_CMD_MS)
`define TCL_MAX_MOVE_CYC     ((`TCL_CLK_HZ / 1000) * `TCL_MAX_MOVE_MS)
`define TCL_LOCK_RETRIES     2'd2
`define TCL_UNLOCK_RETRIES   2'd1

`endif

// file: core/tcl_cmd_filter.v
// Command qualifier: synchronises one command pin and passes it on once it
// has stood high for the minimum width.
// Assumes the pin is asynchronous to aclk.
`timescale 1ns/1ns
`default_nettype none
module tcl_cmd_filter #(
  parameter [31:0] MIN_CYC = 32'd2500000
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire pin,
  output reg  valid_reg
);
  reg        sync1_reg;
  reg        sync2_reg;
  reg [31:0] cnt_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      cnt_reg   <= 32'h0000_0000;
      valid_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      if (!sync2_reg) begin
        cnt_reg   <= 32'h0000_0000;
        valid_reg <= 1'b0;
      end else if (cnt_reg < MIN_CYC - 32'd1) begin
        cnt_reg <= cnt_reg + 32'd1;
      end else begin
        valid_reg <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: core/tcl_lock_seq.v
// Lock and unlock sequencer for the tool changer motor controller.
// Assumes motor feedback (encoder count, stall flag, lock region sensor) on
// aclk, and command pins asynchronous to aclk.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tcl_regs.vh"
module tcl_lock_seq #(
  parameter [31:0] MIN_CMD_CYC  = `TCL_MIN_CMD_CYC,
  parameter [31:0] MAX_MOVE_CYC = `TCL_MAX_MOVE_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        lock_cmd,
  input  wire        release_cmd,
  input  wire        proximity_ok,
  input  wire        lock_region,
  input  wire        extended_empty,
  input  wire        motor_stall,
  input  wire [15:0] enc_count,
  output reg         engaged_reg,
  output reg         released_reg,
  output reg         motor_en_reg,
  output reg         motor_dir_reg,
  output reg         motor_cur_mode_reg,
  output reg         motor_hold_reg,
  output reg  [15:0] motor_target_reg,
  output reg         enc_zero_reg,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  localparam [5:0] ST_IDLE  = 6'b000001;
  localparam [5:0] ST_CUR   = 6'b000010;
  localparam [5:0] ST_POS   = 6'b000100;
  localparam [5:0] ST_CHECK = 6'b001000;
  localparam [5:0] ST_DONE  = 6'b010000;
  localparam [5:0] ST_ABORT = 6'b100000;

  localparam [1:0] LAST_NONE = 2'd0;
  localparam [1:0] LAST_LOCK = 2'd1;
  localparam [1:0] LAST_REL  = 2'd2;

  wire lock_ok;
  wire rel_ok;

  reg [5:0]  state_reg;
  reg        dir_lock_reg;
  reg        homed_reg;
  reg [1:0]  last_reg;
  reg [1:0]  tries_reg;
  reg [31:0] timer_reg;
  reg        timeout_reg;
  reg        abort_flag_reg;
  reg        lock_seen_reg;
  reg        lock_ok_d_reg;
  reg        rel_ok_d_reg;
  reg        pwr_chk_reg;
  reg        hold_en_reg;
  reg [15:0] tol_reg;
  reg        prox_s1_reg;
  reg        prox_s2_reg;

  reg        aw_hold_reg;
  reg [3:0]  aw_addr_reg;
  reg        w_hold_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;

  // Distance between the encoder and a target, used by both move checks.
  function [15:0] abs_diff;
    input [15:0] a;
    input [15:0] b;
    begin
      abs_diff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  function in_tol;
    input [15:0] pos;
    input [15:0] tgt;
    input [15:0] tol;
    begin
      in_tol = (abs_diff(pos, tgt) <= tol);
    end
  endfunction

  tcl_cmd_filter #(.MIN_CYC(MIN_CMD_CYC)) u_lock_filt (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin       (lock_cmd),
    .valid_reg (lock_ok)
  );

  tcl_cmd_filter #(.MIN_CYC(MIN_CMD_CYC)) u_rel_filt (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin       (release_cmd),
    .valid_reg (rel_ok)
  );

  // proximity ignored: proximity_ok only reads back on the status word.

  // Rising edges of qualified commands start moves; one stroke per command.
  wire lock_rise = lock_ok & ~lock_ok_d_reg;
  wire rel_rise  = rel_ok & ~rel_ok_d_reg;
  wire [15:0] goal = dir_lock_reg ? `TCL_LOCK_POS : `TCL_UNLOCK_POS;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg          <= ST_IDLE;
      dir_lock_reg       <= 1'b0;
      homed_reg          <= 1'b0;
      last_reg           <= LAST_NONE;
      tries_reg          <= 2'd0;
      timer_reg          <= 32'h0000_0000;
      timeout_reg        <= 1'b0;
      abort_flag_reg     <= 1'b0;
      lock_ok_d_reg      <= 1'b0;
      rel_ok_d_reg       <= 1'b0;
      pwr_chk_reg        <= 1'b1;
      lock_seen_reg      <= 1'b0;
      engaged_reg        <= 1'b0;
      released_reg       <= 1'b0;
      motor_en_reg       <= 1'b0;
      motor_dir_reg      <= 1'b0;
      motor_cur_mode_reg <= 1'b0;
      motor_hold_reg     <= 1'b0;
      motor_target_reg   <= 16'h0000;
      enc_zero_reg       <= 1'b0;
    end else begin
      lock_ok_d_reg <= lock_ok;
      rel_ok_d_reg  <= rel_ok;
      enc_zero_reg  <= 1'b0;
      lock_seen_reg <= lock_region;
      pwr_chk_reg   <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          motor_en_reg <= 1'b0;
          timer_reg    <= 32'h0000_0000;
          if (pwr_chk_reg && lock_region) begin
            dir_lock_reg       <= 1'b1;
            state_reg          <= ST_CUR;
            motor_en_reg       <= 1'b1;
            motor_dir_reg      <= 1'b1;
            motor_cur_mode_reg <= 1'b1;
            motor_hold_reg     <= 1'b0;
            engaged_reg        <= 1'b0;
            released_reg       <= 1'b0;
          end else if (lock_ok && rel_ok) begin
            state_reg <= ST_IDLE;
          end else if (lock_rise && !(engaged_reg && last_reg == LAST_LOCK)) begin
            dir_lock_reg   <= 1'b1;
            last_reg       <= LAST_LOCK;
            abort_flag_reg <= 1'b0;
            timeout_reg    <= 1'b0;
            motor_en_reg   <= 1'b1;
            motor_dir_reg  <= 1'b1;
            motor_hold_reg <= 1'b0;
            engaged_reg    <= 1'b0;
            released_reg   <= 1'b0;
            tries_reg      <= `TCL_LOCK_RETRIES;
            motor_target_reg <= `TCL_LOCK_POS;
            motor_cur_mode_reg <= ~homed_reg;
            state_reg          <= homed_reg ? ST_POS : ST_CUR;
          end else if (rel_rise && !(released_reg && last_reg == LAST_REL)) begin
            dir_lock_reg   <= 1'b0;
            last_reg       <= LAST_REL;
            abort_flag_reg <= 1'b0;
            timeout_reg    <= 1'b0;
            motor_en_reg   <= 1'b1;
            motor_dir_reg  <= 1'b0;
            motor_hold_reg <= 1'b0;
            engaged_reg    <= 1'b0;
            released_reg   <= 1'b0;
            tries_reg      <= `TCL_UNLOCK_RETRIES;
            motor_target_reg <= `TCL_UNLOCK_POS;
            motor_cur_mode_reg <= ~homed_reg;
            state_reg          <= homed_reg ? ST_POS : ST_CUR;
          end
          if (extended_empty && !motor_hold_reg) begin
            engaged_reg  <= 1'b0;
            released_reg <= 1'b0;
          end
        end
        ST_CUR: begin
          timer_reg <= timer_reg + 32'd1;
          if (motor_stall) begin
            motor_en_reg <= 1'b0;
            state_reg    <= ST_DONE;
            if (!dir_lock_reg) begin
              homed_reg    <= 1'b1;
              enc_zero_reg <= 1'b1;
            end
          end else if (timer_reg >= MAX_MOVE_CYC - 32'd1) begin
            timeout_reg <= 1'b1;
            state_reg   <= ST_ABORT;
          end
        end
        ST_POS: begin
          timer_reg <= timer_reg + 32'd1;
          if (motor_stall || in_tol(enc_count, goal, tol_reg)) begin
            motor_en_reg <= 1'b0;
            state_reg    <= ST_CHECK;
          end else if (timer_reg >= MAX_MOVE_CYC - 32'd1) begin
            timeout_reg <= 1'b1;
            state_reg   <= ST_ABORT;
          end
        end
        ST_CHECK: begin
          if (in_tol(enc_count, goal, tol_reg)) begin
            state_reg <= ST_DONE;
          end else if (tries_reg != 2'd0) begin
            tries_reg    <= tries_reg - 2'd1;
            motor_en_reg <= 1'b1;
            state_reg    <= ST_POS;
          end else begin
            state_reg <= ST_ABORT;
          end
        end
        ST_DONE: begin
          motor_hold_reg <= dir_lock_reg & hold_en_reg;
          engaged_reg    <= dir_lock_reg;
          released_reg   <= ~dir_lock_reg;
          state_reg      <= ST_IDLE;
        end
        ST_ABORT: begin
          motor_en_reg   <= 1'b0;
          abort_flag_reg <= 1'b1;
          last_reg       <= LAST_NONE;
          state_reg      <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // AXI4-Lite slave: address and data taken in either order, one at a time.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h0000_0000;
      aw_hold_reg   <= 1'b0;
      aw_addr_reg   <= 4'h0;
      w_hold_reg    <= 1'b0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      hold_en_reg   <= 1'b1;
      tol_reg       <= `TCL_TOL_RESET;
      prox_s1_reg   <= 1'b0;
      prox_s2_reg   <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_hold_reg & ~s_axi_wready & ~s_axi_bvalid;
      prox_s1_reg   <= proximity_ok;
      prox_s2_reg   <= prox_s1_reg;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_hold_reg && w_hold_reg && !s_axi_bvalid) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        if (aw_addr_reg == `TCL_ADDR_CTRL) begin
          if (w_strb_reg[0]) begin
            hold_en_reg <= w_data_reg[`TCL_CTRL_HOLD_BIT];
          end
        end else if (aw_addr_reg == `TCL_ADDR_TOL) begin
          if (w_strb_reg[0]) begin
            tol_reg[7:0] <= w_data_reg[7:0];
          end
          if (w_strb_reg[1]) begin
            tol_reg[15:8] <= w_data_reg[15:8];
          end
        end else if (aw_addr_reg != `TCL_ADDR_STATUS &&
                     aw_addr_reg != `TCL_ADDR_POS) begin
          s_axi_bresp <= 2'b10;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `TCL_ADDR_CTRL: begin
            s_axi_rdata <= {31'd0, hold_en_reg};
          end
          `TCL_ADDR_STATUS: begin
            s_axi_rdata <= {21'd0, timeout_reg, abort_flag_reg, prox_s2_reg,
                            lock_seen_reg, homed_reg, last_reg,
                            motor_hold_reg, state_reg == ST_IDLE,
                            engaged_reg, released_reg};
          end
          `TCL_ADDR_POS: begin
            s_axi_rdata <= {16'd0, enc_count};
          end
          `TCL_ADDR_TOL: begin
            s_axi_rdata <= {16'd0, tol_reg};
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/tcl_lock_seq_props.sv
// Port checks for the lock sequencer.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module tcl_lock_seq_props #(
  parameter [31:0] MAX_MOVE_CYC = 32'h0000_00C8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lock_region,
  input wire logic extended_empty,
  input wire logic motor_stall,
  input wire logic engaged_reg,
  input wire logic released_reg,
  input wire logic motor_en_reg,
  input wire logic motor_dir_reg,
  input wire logic motor_cur_mode_reg,
  input wire logic motor_hold_reg,
  input wire logic enc_zero_reg
);
  logic [31:0] on_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Counts how long the motor has been driven without a break.
  always_ff @(posedge aclk) begin
    if (!aresetn || !motor_en_reg) on_cnt <= 32'h0000_0000;
    else on_cnt <= on_cnt + 32'h0000_0001;
  end
  sequence s_home;
    enc_zero_reg ##1 (!enc_zero_reg && released_reg);
  endsequence
  sequence s_empty;
    (extended_empty && !motor_en_reg && !motor_hold_reg) [*4];
  endsequence
  property p_still;
    $rose(aresetn) && !lock_region |-> !motor_en_reg [*8];
  endproperty
  property p_retight;
    $rose(aresetn) && lock_region
      |-> ##[1:4] motor_en_reg && motor_dir_reg && motor_cur_mode_reg;
  endproperty
  property p_excl;
    !(engaged_reg && released_reg);
  endproperty
  property p_home;
    $rose(enc_zero_reg) |-> s_home;
  endproperty
  property p_bound;
    on_cnt <= MAX_MOVE_CYC + 32'h0000_0002;
  endproperty
  property p_stall;
    motor_en_reg && motor_cur_mode_reg && motor_stall
      |-> ##[1:2] !motor_en_reg;
  endproperty
  property p_hold;
    motor_hold_reg |-> engaged_reg;
  endproperty
  property p_empty;
    s_empty |-> !engaged_reg && !released_reg;
  endproperty
  a_still: assert property (p_still)
    else $error("motor moved without command");
  a_retight: assert property (p_retight)
    else $error("no retighten from locked region");
  a_excl: assert property (p_excl)
    else $error("both status lines high");
  a_home: assert property (p_home)
    else $error("homing pulse without released status");
  a_bound: assert property (p_bound)
    else $error("move ran too long");
  a_stall: assert property (p_stall)
    else $error("current move kept on after stall");
  a_hold: assert property (p_hold)
    else $error("holding force while not locked");
  a_empty: assert property (p_empty)
    else $error("status shown with mechanism empty");
endmodule
bind tcl_lock_seq tcl_lock_seq_props #(.MAX_MOVE_CYC(MAX_MOVE_CYC)) i_props (
  .aclk(aclk), .aresetn(aresetn), .lock_region(lock_region),
  .extended_empty(extended_empty), .motor_stall(motor_stall),
  .engaged_reg(engaged_reg), .released_reg(released_reg),
  .motor_en_reg(motor_en_reg), .motor_dir_reg(motor_dir_reg),
  .motor_cur_mode_reg(motor_cur_mode_reg),
  .motor_hold_reg(motor_hold_reg), .enc_zero_reg(enc_zero_reg)
);
`default_nettype wire

// file: verification/tcl_robot_model.sv
// Robot-side model driving the lock and release command pins.
// Assumes it is called just after a rising edge of aclk.
`timescale 1ns/1ns
`default_nettype none
module tcl_robot_model (
  input  wire logic aclk,
  output var  logic lock_cmd,
  output var  logic release_cmd,
  output var  logic proximity_ok
);
  logic [7:0] hold_cnt = 8'h00;
  initial begin
    lock_cmd = 1'b0;
    release_cmd = 1'b0;
    proximity_ok = 1'b0;
  end
  // Raises a command for width cycles: 0 lock, 1 release, 2 both.
  task automatic start(input logic [1:0] kind, input logic [7:0] width);
    @(posedge aclk);
    lock_cmd <= 1'b0;
    release_cmd <= 1'b0;
    proximity_ok <= (kind != 2'd1);
    @(posedge aclk);
    lock_cmd <= (kind != 2'd1);
    release_cmd <= (kind != 2'd0);
    hold_cnt <= width;
  endtask
  always @(posedge aclk) begin
    if (hold_cnt == 8'h01) begin
      lock_cmd <= 1'b0;
      release_cmd <= 1'b0;
    end
    if (hold_cnt != 8'h00) hold_cnt <= hold_cnt - 8'h01;
  end
endmodule
`default_nettype wire

// file: verification/test_tool_changer_lock_sequencer.sv
// Bench for the lock sequencer with robot model and mechanism stand-in.
// Assumes 20 cycles to qualify a command and 200 as the move limit.
`timescale 1ns/1ns
`default_nettype none
module test_tool_changer_lock_sequencer;
  logic        aclk = 1'b0, aresetn = 1'b0, en_d = 1'b0, jam = 1'b0;
  logic        lock_region = 1'b1, extended_empty = 1'b0, stuck = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [15:0] enc_count = 16'h0400;
  logic [1:0]  mode_cap = 2'b00;
  wire logic   lock_cmd, release_cmd, proximity_ok, motor_stall;
  wire logic   engaged_reg, released_reg, motor_en_reg, motor_dir_reg;
  wire logic   motor_cur_mode_reg, motor_hold_reg, enc_zero_reg;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic   s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] motor_target_reg, goal;
  int          error_cnt = 0, samples_checked = 0, cyc = 0;
  int          rises = 0, zeros = 0, on_cnt = 0;
  tcl_lock_seq #(
    .MIN_CMD_CYC(32'h0000_0014), .MAX_MOVE_CYC(32'h0000_00C8)
  ) i_dut (
    .aclk, .aresetn, .lock_cmd, .release_cmd, .proximity_ok, .lock_region,
    .extended_empty, .motor_stall, .enc_count, .engaged_reg, .released_reg,
    .motor_en_reg, .motor_dir_reg, .motor_cur_mode_reg, .motor_hold_reg,
    .motor_target_reg, .enc_zero_reg, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  tcl_robot_model i_robot (.aclk, .lock_cmd, .release_cmd, .proximity_ok);
  initial begin
    forever #10 aclk = ~aclk;
  end
  // The mechanism steps 0x100 a cycle; a jam stops it and stalls later.
  // A stuck mechanism neither moves nor stalls, so only the limit ends it.
  assign goal = motor_cur_mode_reg ? {4'h0, motor_dir_reg, 11'h000}
                                   : motor_target_reg;
  assign motor_stall = motor_en_reg && !stuck &&
    (jam ? on_cnt > 8 : motor_cur_mode_reg && enc_count == goal);
  always @(posedge aclk) begin
    on_cnt <= motor_en_reg ? on_cnt + 1 : 0;
    en_d <= motor_en_reg;
    if (motor_en_reg && !en_d) begin
      rises <= rises + 1;
      mode_cap <= {motor_cur_mode_reg, motor_dir_reg};
    end
    if (enc_zero_reg) zeros <= zeros + 1;
    if (enc_zero_reg) enc_count <= 16'h0000;
    else if (motor_en_reg && !jam && !stuck && enc_count != goal)
      enc_count <= enc_count < goal ? enc_count + 16'h0100
                                    : enc_count - 16'h0100;
    cyc <= cyc + 1;
    // The whole run needs about 1500 cycles.
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic settle;
    int quiet;
    quiet = 0;
    while (quiet < 60) begin
      @(posedge aclk);
      quiet = motor_en_reg ? 0 : quiet + 1;
    end
  endtask
  task automatic move(input logic [1:0] kind, input logic [7:0] width,
                      input int n, input logic [1:0] mode,
                      input logic [1:0] stat);
    int base;
    base = rises;
    i_robot.start(kind, width);
    settle();
    chk(rises - base, n);
    if (n > 0) chk(mode_cap, mode);
    chk({engaged_reg, released_reg}, stat);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, (a[1:0] != 2'b00) ? 2'b10 : 2'b00);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, (a[1:0] != 2'b00) ? 2'b10 : 2'b00);
  endtask
  task automatic t_retighten;
    settle();
    chk(rises, 1);
    chk(mode_cap, 2'b11);
    chk({engaged_reg, released_reg}, 2'b10);
  endtask
  task automatic t_home_and_repeat;
    int zb;
    zb = zeros;
    move(2'd1, 8'd40, 1, 2'b10, 2'b01);
    chk(zeros - zb, 1);
    move(2'd1, 8'd40, 0, 2'b00, 2'b01);
    chk({engaged_reg, released_reg}, 2'b01);
    move(2'd0, 8'd40, 1, 2'b01, 2'b10);
    chk(motor_hold_reg, 1'b1);
    move(2'd0, 8'd40, 0, 2'b00, 2'b10);
  endtask
  task automatic t_rejects;
    move(2'd2, 8'd40, 0, 2'b00, 2'b10);
    move(2'd1, 8'd10, 0, 2'b00, 2'b10);
  endtask
  task automatic t_regs;
    axi_rd(4'h0, 32'h0000_0001);
    axi_rd(4'hC, 32'h0000_0010);
    axi_rd(4'h8, {16'h0000, enc_count});
    axi_wr(4'h4, 32'hFFFF_FFFF);
    axi_wr(4'h0, 32'h0000_0000);
    axi_rd(4'h0, 32'h0000_0000);
    axi_wr(4'h0, 32'h0000_0001);
    axi_wr(4'h2, 32'h0000_0000);
    axi_rd(4'h1, 32'h0000_0000);
  endtask
  task automatic t_jams;
    jam <= 1'b1;
    move(2'd1, 8'd40, 2, 2'b00, 2'b00);
    jam <= 1'b0;
    move(2'd1, 8'd40, 1, 2'b00, 2'b01);
    jam <= 1'b1;
    move(2'd0, 8'd40, 3, 2'b01, 2'b00);
    jam <= 1'b0;
    move(2'd1, 8'd40, 1, 2'b00, 2'b01);
  endtask
  task automatic t_timeout;
    stuck <= 1'b1;
    move(2'd0, 8'd40, 1, 2'b01, 2'b00);
    axi_rd(4'h4, 32'h0000_07C4);
    stuck <= 1'b0;
    move(2'd1, 8'd40, 1, 2'b00, 2'b01);
  endtask
  task automatic t_extended;
    extended_empty <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({engaged_reg, released_reg}, 2'b00);
    extended_empty <= 1'b0;
  endtask
  task automatic t_still;
    int base;
    @(posedge aclk);
    aresetn <= 1'b0;
    lock_region <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    base = rises;
    repeat (100) @(posedge aclk);
    chk(rises - base, 0);
    chk({engaged_reg, released_reg}, 2'b00);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_retighten();
    t_home_and_repeat();
    t_rejects();
    t_regs();
    t_jams();
    t_timeout();
    t_extended();
    t_still();
    finish_test();
  end
endmodule
`default_nettype wire
